//--- rtl/smartcard_uart_defines.vh
// constants shared by the smart card uart data and status block
// Function
// - a written character starts sending five clocks after the write strobe rise is sampled
// - a character written during extra guard time starts when that time expires
// - after a card rejection, resend starts at 13.5 or 15 etu by mode
// - no new transmission begins while a character is still being sent
// - in t0, transmit empty set at 11.5 etu, parity error flagged on rejection
// - in t1, transmit empty set at 10.5 etu after the start bit
// - transmit data is sent in direct convention, least significant bit first
// - synchronous card mode drives transmit bit zero straight onto the line
// - writes are held before transmission mode is enabled
// - transmit and receive registers share offset 0D, write versus read
// - synchronous card mode: receive bit zero reflects the line level
// - received parity error sets its flag at 10.5 etu and pulls irq low
// - parity-error characters are dropped in t0 and stored in t1
// - receive full set at 10.5 etu on store, cleared by reading receive data
// - status bit 6 is one while the receive fifo is empty
// - status bit 7 follows clock switch completion, cleared by soft reset
// - in t1, a 22 etu counter from each start bit sets status bit 5
// - in t0, the guard bit follows a 16 etu counter instead
// - status bit 2 shows card presence
// - after reset the empty/full bit is 0, fifo empty is 1, bits 4,3,1 zero
// - empty/full clears on soft reset, transmit write, receive read, switch to receive mode
// - no mixed status bit drives the interrupt output
`ifndef SMARTCARD_UART_DEFINES_VH
`define SMARTCARD_UART_DEFINES_VH
`define ADDR_MIXED_STATUS   8'h0C
`define ADDR_DATA           8'h0D
`define MSR_CLOCK_SWITCH_DONE_BIT       7
`define MSR_FIFO_EMPTY_BIT  6
`define MSR_BGT_BIT         5
`define MSR_PRESENT_BIT     2
`define MSR_TX_EMPTY_RX_FULL_FLAG_BIT     0
`define RESET_BYTE          8'h00
`define WR_START_DELAY      2'h2
// etu figures in half etu units
`define HETU_T1_FLAG        6'h15
`define HETU_T0_FLAG        6'h17
`define HETU_REP_MANUAL     6'h1B
`define HETU_REP_AUTO       6'h1E
`define HETU_BGT_T1         6'h2C
`define HETU_BGT_T0         6'h20
`define HETU_RX_SAMPLE_BASE 6'h02
`define HETU_PARITY_NAK     6'h15
`define CHAR_BITS           4'hA
`endif

//--- rtl/char_buffer.v
// two-entry valid/ready buffer for received characters
module char_buffer
(
   input  wire       sys_clk,
   input  wire       reset,
   input  wire       in_valid,
   output wire       in_ready,
   input  wire [7:0] in_data,
   output wire       out_valid,
   input  wire       out_ready,
   output reg  [7:0] out_data
);
   reg [7:0] slot_reg;
   reg [1:0] count_reg;
   wire      push;
   wire      pop;

   assign in_ready  = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   ////////////////////////////////////////////////////////////////////////
   // head stays in out_data, second entry waits in slot
   always @(posedge sys_clk)
   begin
      if (reset)
      begin
         count_reg <= 2'h0;
         out_data  <= 8'h00;
         slot_reg  <= 8'h00;
      end
      else
      begin
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
         if (pop && count_reg == 2'h2)
            out_data <= slot_reg;
         else if (push && (count_reg == 2'h0 || (pop && count_reg == 2'h1)))
            out_data <= in_data;
         if (push && count_reg != 2'h0 && !(pop && count_reg == 2'h1))
            slot_reg <= in_data;
      end
   end
endmodule

//--- rtl/smartcard_uart_data_status.v
// character data path and mixed status of the smart card uart
`include "smartcard_uart_defines.vh"
module smartcard_uart_data_status
(
   input  wire       sys_clk,
   input  wire       reset,
   input  wire [7:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr_n,
   input  wire       rd_n,
   output reg  [7:0] rdata,
   input  wire       half_etu_tick,
   input  wire       protocol_t1,
   input  wire       tx_mode,
   input  wire       auto_repeat,
   input  wire       sync_card_select,
   input  wire       extra_guard_running,
   input  wire       clock_switch_to_half,
   input  wire       clock_switch_to_xtal,
   input  wire       soft_reset_bit,
   input  wire       presence_contact,
   input  wire       io_in,
   output reg        io_out,
   output reg        io_oe,
   output wire       irq_n,
   output reg        tx_empty_flag,
   output reg        parity_error_flag,
   output reg        rx_full_flag
);
   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_SEND = 2'h2;
   localparam ST_RX   = 2'h3;

   reg  [7:0] tx_holding_reg;
   reg        tx_pending_reg;
   reg  [1:0] wr_delay_reg;
   reg  [1:0] state_reg;
   reg  [5:0] hetu_reg;
   reg  [9:0] shift_reg;
   reg        nak_seen_reg;
   reg        resend_reg;
   reg        bgt_flag_reg;
   reg  [5:0] bgt_cnt_reg;
   reg        clock_switch_done_reg;
   reg        tx_mode_reg;
   reg  [2:0] wr_sync_reg;
   reg  [2:0] rd_sync_reg;
   reg  [2:0] io_sync_reg;
   reg  [1:0] presence_contact_sync_reg;
   reg        rx_valid_reg;
   reg  [7:0] rx_char_reg;
   wire       wr_rise;
   wire       rd_fall;
   wire       io_level;
   wire       start_edge;
   wire       rx_read;
   wire       buf_ready;
   wire       buf_valid;
   wire [7:0] buf_data;
   wire [7:0] mixed_status_reg;

   ////////////////////////////////////////////////////////////////////////
   // even parity over data plus parity bit: an even count of ones is good
   function parity_ok;
      input [8:0] bits;
      begin
         parity_ok = ~^bits;
      end
   endfunction

   function addr_hit;
      input [7:0] a;
      input [7:0] ref_a;
      begin
         addr_hit = (a == ref_a);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pins come from outside, two flops before any logic looks at them
   always @(posedge sys_clk)
   begin
      if (reset)
      begin
         wr_sync_reg   <= 3'h7;
         rd_sync_reg   <= 3'h7;
         io_sync_reg   <= 3'h7;
         presence_contact_sync_reg <= 2'h0;
      end
      else
      begin
         wr_sync_reg   <= {wr_sync_reg[1:0], wr_n};
         rd_sync_reg   <= {rd_sync_reg[1:0], rd_n};
         io_sync_reg   <= {io_sync_reg[1:0], io_in};
         presence_contact_sync_reg <= {presence_contact_sync_reg[0], presence_contact};
      end
   end

   // edges are taken only from second and third stages
   assign wr_rise    = wr_sync_reg[1] & ~wr_sync_reg[2];
   assign rd_fall    = ~rd_sync_reg[1] & rd_sync_reg[2];
   assign io_level   = io_sync_reg[1];
   assign start_edge = ~io_sync_reg[1] & io_sync_reg[2];
   assign rx_read    = rd_fall & addr_hit(addr, `ADDR_DATA);

   ////////////////////////////////////////////////////////////////////////
   // host write into the transmit holding register
   always @(posedge sys_clk)
   begin
      if (reset)
      begin
         tx_holding_reg <= `RESET_BYTE;
         tx_pending_reg <= 1'b0;
         wr_delay_reg   <= 2'h0;
      end
      else
      begin
         if (wr_rise && addr_hit(addr, `ADDR_DATA))
         begin
            tx_holding_reg <= wdata;
            tx_pending_reg <= 1'b1;
            wr_delay_reg   <= `WR_START_DELAY;
         end
         else
         begin
            if (wr_delay_reg != 2'h0)
               wr_delay_reg <= wr_delay_reg - 2'h1;
            if (state_reg == ST_IDLE && tx_pending_reg && tx_mode && !sync_card_select
                && wr_delay_reg == 2'h0 && !extra_guard_running && !resend_reg)
               tx_pending_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // character engine: send, resend wait and receive share one timer
   always @(posedge sys_clk)
   begin
      if (reset)
      begin
         state_reg         <= ST_IDLE;
         hetu_reg          <= 6'h00;
         shift_reg         <= 10'h3FF;
         nak_seen_reg      <= 1'b0;
         resend_reg        <= 1'b0;
         io_out            <= 1'b1;
         io_oe             <= 1'b0;
         tx_empty_flag     <= 1'b0;
         parity_error_flag <= 1'b0;
         rx_full_flag      <= 1'b0;
         rx_valid_reg      <= 1'b0;
         rx_char_reg       <= `RESET_BYTE;
      end
      else
      begin
         rx_valid_reg <= 1'b0;
         if (rx_read || soft_reset_bit)
            rx_full_flag <= 1'b0;
         if (wr_rise && addr_hit(addr, `ADDR_DATA))
            tx_empty_flag <= 1'b0;
         if (sync_card_select)
         begin
            io_oe  <= tx_mode;
            io_out <= tx_holding_reg[0];
         end
         case (state_reg)
            ST_IDLE:
            begin
               io_oe  <= sync_card_select & tx_mode;
               if (!sync_card_select)
                  io_out <= 1'b1;
               // only leaves idle once the prior character has ended
               if (tx_pending_reg && tx_mode && !sync_card_select && wr_delay_reg == 2'h0
                   && !extra_guard_running && !resend_reg)
               begin
                  state_reg <= ST_SEND;
                  shift_reg <= {^tx_holding_reg, tx_holding_reg, 1'b0};
                  hetu_reg  <= 6'h00;
                  io_oe     <= 1'b1;
                  io_out    <= 1'b0;
               end
               else if (resend_reg)
               begin
                  state_reg <= ST_WAIT;
               end
               else if (start_edge && !tx_mode && !sync_card_select)
               begin
                  state_reg <= ST_RX;
                  hetu_reg  <= 6'h00;
               end
            end
            ST_SEND:
            begin
               if (half_etu_tick)
               begin
                  hetu_reg <= hetu_reg + 6'h01;
                  // bits change on odd ticks so the start bit is close to one etu,
                  // the tick phase is free so it may come up to a half etu short
                  if (hetu_reg[0] && hetu_reg < {1'b0, `CHAR_BITS, 1'b0} - 6'h02)
                  begin
                     io_out    <= shift_reg[1];
                     shift_reg <= {1'b1, shift_reg[9:1]};
                  end
                  if (hetu_reg == {1'b0, `CHAR_BITS, 1'b0} - 6'h01)
                     io_oe <= 1'b0;
                  if (hetu_reg == `HETU_PARITY_NAK && !protocol_t1 && !io_level)
                     nak_seen_reg <= 1'b1;
                  if (protocol_t1 && hetu_reg == `HETU_T1_FLAG - 6'h01)
                  begin
                     tx_empty_flag <= 1'b1;
                     state_reg     <= ST_IDLE;
                  end
                  if (!protocol_t1 && hetu_reg == `HETU_T0_FLAG - 6'h01)
                  begin
                     tx_empty_flag <= ~nak_seen_reg;
                     if (nak_seen_reg)
                     begin
                        parity_error_flag <= 1'b1;
                        resend_reg        <= 1'b1;
                        state_reg         <= ST_WAIT;
                     end
                     else
                        state_reg <= ST_IDLE;
                     nak_seen_reg <= 1'b0;
                  end
               end
            end
            ST_WAIT:
            begin
               // resend point counted from the rejected start bit, taken on a
               // tick so it never lands ahead of the half etu mark
               if (half_etu_tick)
               begin
                  hetu_reg <= hetu_reg + 6'h01;
                  if (hetu_reg >= (auto_repeat ? `HETU_REP_AUTO : `HETU_REP_MANUAL))
                  begin
                     resend_reg <= 1'b0;
                     state_reg  <= ST_SEND;
                     shift_reg  <= {^tx_holding_reg, tx_holding_reg, 1'b0};
                     hetu_reg   <= 6'h00;
                     io_oe      <= 1'b1;
                     io_out     <= 1'b0;
                  end
               end
            end
            ST_RX:
            begin
               if (half_etu_tick)
               begin
                  hetu_reg <= hetu_reg + 6'h01;
                  if (!hetu_reg[0] && hetu_reg >= `HETU_RX_SAMPLE_BASE) // near mid bit
                     shift_reg <= {io_level, shift_reg[9:1]};
                  if (hetu_reg == `HETU_T1_FLAG - 6'h01)
                  begin
                     state_reg <= ST_IDLE;
                     if (!parity_ok(shift_reg[9:1]))
                        parity_error_flag <= 1'b1;
                     if (parity_ok(shift_reg[9:1]) || protocol_t1)
                     begin
                        rx_valid_reg <= 1'b1;
                        rx_char_reg  <= shift_reg[8:1];
                        rx_full_flag <= 1'b1;
                     end
                  end
               end
            end
            default:
               state_reg <= ST_IDLE;
         endcase
         if (tx_mode != tx_mode_reg && !tx_mode)
            tx_empty_flag <= 1'b0;
         if (soft_reset_bit)
         begin
            tx_empty_flag     <= 1'b0;
            parity_error_flag <= 1'b0;
         end
      end
   end

   // parity flag is the only source of the interrupt
   assign irq_n = ~parity_error_flag;

   ////////////////////////////////////////////////////////////////////////
   // receive buffer: host drains it on read; a character arriving while both entries are full is lost
   char_buffer rx_buffer
   (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .in_valid  (rx_valid_reg),
      .in_ready  (buf_ready),
      .in_data   (rx_char_reg),
      .out_valid (buf_valid),
      .out_ready (rx_read),
      .out_data  (buf_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // block guard counter restarts at each start bit
   always @(posedge sys_clk)
   begin
      if (reset)
      begin
         bgt_cnt_reg  <= 6'h00;
         bgt_flag_reg <= 1'b0;
         tx_mode_reg  <= 1'b0;
      end
      else
      begin
         tx_mode_reg <= tx_mode;
         if (start_edge)
         begin
            bgt_cnt_reg  <= 6'h00;
            bgt_flag_reg <= 1'b0;
         end
         else if (half_etu_tick && !bgt_flag_reg)
         begin
            bgt_cnt_reg <= bgt_cnt_reg + 6'h01;
            if (bgt_cnt_reg == (protocol_t1 ? `HETU_BGT_T1 : `HETU_BGT_T0) - 6'h01)
               bgt_flag_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clock switch completion; set wins over clear
   always @(posedge sys_clk)
   begin
      if (reset)
         clock_switch_done_reg <= 1'b0;
      else if (clock_switch_to_half)
         clock_switch_done_reg <= 1'b1;
      else if (clock_switch_to_xtal || soft_reset_bit)
         clock_switch_done_reg <= 1'b0;
   end

   assign mixed_status_reg = {clock_switch_done_reg, ~buf_valid, bgt_flag_reg, 2'b00,
                              presence_contact_sync_reg[1], 1'b0,
                              tx_empty_flag | rx_full_flag};

   ////////////////////////////////////////////////////////////////////////
   // read data, registered
   always @(posedge sys_clk)
   begin
      if (reset)
         rdata <= `RESET_BYTE;
      else if (addr_hit(addr, `ADDR_MIXED_STATUS))
         rdata <= mixed_status_reg;
      else if (addr_hit(addr, `ADDR_DATA))
         rdata <= sync_card_select ? {7'h00, io_level} : buf_data;
      else
         rdata <= `RESET_BYTE;
   end
endmodule

//--- tb/smartcard_uart_data_status_sva.sv
// assertion checker for the smart card uart data and status block
module smartcard_uart_data_status_sva
(
   input wire logic       sys_clk,
   input wire logic       reset,
   input wire logic [7:0] addr,
   input wire logic       wr_n,
   input wire logic [7:0] rdata,
   input wire logic       sync_card_select,
   input wire logic       extra_guard_running,
   input wire logic       clock_switch_to_half,
   input wire logic       clock_switch_to_xtal,
   input wire logic       soft_reset_bit,
   input wire logic       presence_contact,
   input wire logic       io_out,
   input wire logic       io_oe,
   input wire logic       irq_n,
   input wire logic       tx_empty_flag,
   input wire logic       parity_error_flag,
   input wire logic       rx_full_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   // one domain, nothing judged while reset is high
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   ////////////////////////////////////////
   // status reads wait five steady cycles: register stage plus sync
   AST_IRQ_IS_PE: assert property (irq_n == !parity_error_flag)
      else $error("irq_n disagrees with parity flag");
   AST_RESET_IDLE: assert property ($past(reset) |-> !io_oe && io_out && irq_n
      && !tx_empty_flag && !rx_full_flag && !parity_error_flag)
      else $error("outputs not idle after reset");
   AST_START_LOW: assert property ($rose(io_oe) && !sync_card_select |-> !io_out)
      else $error("drive began without a low start bit");
   AST_GUARD_WAIT: assert property ($rose(io_oe) |-> !$past(extra_guard_running))
      else $error("start bit during extra guard time");
   AST_PRESENT_BIT: assert property ((addr == 8'h0C && $stable(presence_contact))[*5]
      |-> rdata[2] == presence_contact)
      else $error("presence bit wrong");
   AST_UNUSED_ZERO: assert property ((addr == 8'h0C)[*5] |-> rdata[4:3] == 2'h0 && !rdata[1])
      else $error("unused status bits not zero");
   AST_FLAG_MERGE: assert property ((addr == 8'h0C && $stable(tx_empty_flag)
      && $stable(rx_full_flag))[*5] |-> rdata[0] == (tx_empty_flag | rx_full_flag))
      else $error("status bit 0 wrong");
   AST_CLOCK_SWITCH_DONE_SET: assert property (clock_switch_to_half ##1 (addr == 8'h0C
      && !clock_switch_to_xtal && !soft_reset_bit)[*5] |-> rdata[7])
      else $error("clock switch bit not set");
   AST_WRITE_CLEARS: assert property ($rose(wr_n) && addr == 8'h0D |-> ##[1:5] !tx_empty_flag)
      else $error("write did not clear transmit empty");
   // main scenarios reached
   cover property ($rose(tx_empty_flag));
   cover property ($rose(rx_full_flag));
   cover property ($fell(irq_n));
endmodule
bind smartcard_uart_data_status smartcard_uart_data_status_sva i_sva
(
   .sys_clk(sys_clk), .reset(reset), .addr(addr), .wr_n(wr_n), .rdata(rdata),
   .sync_card_select(sync_card_select), .extra_guard_running(extra_guard_running),
   .clock_switch_to_half(clock_switch_to_half), .clock_switch_to_xtal(clock_switch_to_xtal),
   .soft_reset_bit(soft_reset_bit), .presence_contact(presence_contact), .io_out(io_out),
   .io_oe(io_oe), .irq_n(irq_n), .tx_empty_flag(tx_empty_flag),
   .parity_error_flag(parity_error_flag), .rx_full_flag(rx_full_flag)
);

//--- tb/card_model.sv
// smart card model on the open-drain io line, one etu is eight clocks
module card_model
(
   input  wire logic sys_clk,
   input  wire logic line,
   input  wire logic nak_en,
   input  wire logic hold_low,
   output wire logic pull_low
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got_q[$];
   logic [7:0] sh;
   logic       drv_low = 1'b0;
   logic       busy = 1'b0;
   int         c = -1;
   // only ever pulls low, the pull-up gives the released level
   assign pull_low = drv_low | hold_low | (nak_en && c >= 81 && c < 97);
   ////////////////////////////////////////
   // watch device frames, sample each bit near its middle
   always @(posedge sys_clk)
   begin
      if (c < 0 && !line && !busy && !hold_low)
         c <= 0;
      else if (c >= 0)
         c <= (c == 100) ? -1 : c + 1;
      if (c >= 10 && c <= 66 && c % 8 == 2)
         sh[(c - 10) / 8] <= line;
      if (c == 100)
         got_q.push_back(sh);
   end
   // send one character, even parity unless told to spoil it
   task automatic send(input logic [7:0] v, input logic bad);
      logic [8:0] f;
      f = {^v ^ bad, v};
      busy = 1'b1;
      for (int i = -1; i < 9; i++)
      begin
         @(posedge sys_clk);
         drv_low <= (i < 0) ? 1'b1 : ~f[i];
         repeat (7) @(posedge sys_clk);
      end
      @(posedge sys_clk);
      drv_low <= 1'b0;
      repeat (16) @(posedge sys_clk);
      busy = 1'b0;
   endtask
endmodule

//--- tb/tb_top.sv
// self-checking testbench for the smart card uart data and status block
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic       sys_clk = 0, reset = 1, wr_n = 1, rd_n = 1, half_etu_tick = 0;
   logic       protocol_t1 = 1, tx_mode = 0, auto_repeat = 0, sync_card_select = 0;
   logic       extra_guard_running = 0, clock_switch_to_half = 0, clock_switch_to_xtal = 0;
   logic       soft_reset_bit = 0, presence_contact = 0, nak_en = 0, hold_low = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, d;
   logic [1:0] tdiv = 2'h0;
   logic [7:0] exp_tx[$], exp_rx[$];
   wire        io_out, io_oe, irq_n, tx_empty_flag, parity_error_flag, rx_full_flag, pull_low;
   wire  [7:0] rdata;
   wire        io_line = (io_oe ? io_out : 1'b1) & ~pull_low;
   int         error_cnt = 0, compares = 0, cyc = 0, n, t;
   smartcard_uart_data_status i_dut
   (
      .sys_clk(sys_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_n(wr_n),
      .rd_n(rd_n), .rdata(rdata), .half_etu_tick(half_etu_tick), .protocol_t1(protocol_t1),
      .tx_mode(tx_mode), .auto_repeat(auto_repeat), .sync_card_select(sync_card_select),
      .extra_guard_running(extra_guard_running), .clock_switch_to_half(clock_switch_to_half),
      .clock_switch_to_xtal(clock_switch_to_xtal), .soft_reset_bit(soft_reset_bit),
      .presence_contact(presence_contact), .io_in(io_line), .io_out(io_out), .io_oe(io_oe),
      .irq_n(irq_n), .tx_empty_flag(tx_empty_flag), .parity_error_flag(parity_error_flag),
      .rx_full_flag(rx_full_flag)
   );
   card_model i_card
   (
      .sys_clk(sys_clk), .line(io_line), .nak_en(nak_en), .hold_low(hold_low),
      .pull_low(pull_low)
   );
   ////////////////////////////////////////
   // 100 MHz clock
   initial
   begin
      forever #5 sys_clk = ~sys_clk;
   end
   // half etu tick every four clocks, plus a free cycle count
   always @(posedge sys_clk)
   begin
      tdiv <= tdiv + 2'h1;
      half_etu_tick <= &tdiv;
      cyc <= cyc + 1;
   end
   ////////////////////////////////////////
   task automatic clk(int k);
      repeat (k) @(posedge sys_clk);
   endtask
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // data held four clocks past the strobe rise
   task automatic wr(logic [7:0] a, logic [7:0] v);
      addr <= a;
      wdata <= v;
      wr_n <= 1'b0;
      clk(3);
      wr_n <= 1'b1;
      clk(4);
   endtask
   // sample before the strobe, since the pop moves the head
   task automatic rd(logic [7:0] a, output logic [7:0] q);
      addr <= a;
      clk(5);
      q = rdata;
      rd_n <= 1'b0;
      clk(3);
      rd_n <= 1'b1;
      clk(3);
   endtask
   task automatic wait_oe();
      int k;
      for (k = 0; k < 3000 && io_oe !== 1'b1; k++)
         @(posedge sys_clk);
      chk("oe_wait", 1, k < 3000);
   endtask
   task automatic drain_tx();
      clk(20);
      chk("card_count", exp_tx.size(), i_card.got_q.size());
      while (exp_tx.size() && i_card.got_q.size())
         chk("card_byte", exp_tx.pop_front(), i_card.got_q.pop_front());
   endtask
   task automatic sr();
      soft_reset_bit <= 1'b1;
      clk(3);
      soft_reset_bit <= 1'b0;
      clk(3);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////
   // hang guard, far beyond the few thousand cycles the tests need
   initial
   begin
      clk(20000);
      error_cnt++;
      wrap_up();
   end
   initial
   begin
      void'($urandom(22));
      clk(8);
      reset <= 1'b0;
      clk(5);
      rd(8'h0C, d); chk("status", 8'h40, d);
      presence_contact <= 1'b1;
      rd(8'h0C, d); chk("status", 8'h44, d);
      $display("test status done");
      // t1 held by guard time, t0 held by receive mode
      for (int p = 1; p >= 0; p--)
      begin
         protocol_t1 <= p;
         tx_mode <= p;
         extra_guard_running <= p;
         d = $urandom;
         exp_tx.push_back(d);
         wr(8'h0D, d);
         clk(30);
         chk("io_oe_held", 0, io_oe);
         tx_mode <= 1'b1;
         extra_guard_running <= 1'b0;
         wait_oe();
         for (n = 0; tx_empty_flag !== 1'b1 && n < 60; n += half_etu_tick)
            @(posedge sys_clk);
         t = p ? 21 : 23;
         chk("empty_ticks", 1, n >= t - 1 && n <= t + 1);
         drain_tx();
         rd(8'h0C, d); chk("status", 8'h45, d & 8'hDF);
      end
      $display("test transmit done");
      // card rejects once, manual then automatic repetition
      for (int a = 0; a < 2; a++)
      begin
         auto_repeat <= a;
         nak_en <= 1'b1;
         d = $urandom;
         exp_tx.push_back(d);
         exp_tx.push_back(d);
         wr(8'h0D, d);
         wait_oe();
         t = cyc;
         clk(100);
         nak_en <= 1'b0;
         chk("pe_flag", 1, parity_error_flag);
         chk("irq_n", 0, irq_n);
         wait_oe();
         t = cyc - t - (a ? 120 : 108);
         chk("resend_gap", 1, t >= 0 && t <= 8);
         clk(110);
         drain_tx();
         sr();
         chk("irq_n", 1, irq_n);
      end
      $display("test repeat done");
      // two stored characters, then one with spoilt parity
      tx_mode <= 1'b0;
      for (int p = 1; p >= 0; p--)
      begin
         protocol_t1 <= p;
         repeat (2)
         begin
            d = $urandom;
            exp_rx.push_back(d);
            i_card.send(d, 1'b0);
         end
         chk("rx_full", 1, rx_full_flag);
         rd(8'h0C, d); chk("status", 8'h05, d & 8'h5F);
         repeat (2)
         begin
            rd(8'h0D, d); chk("rx_byte", exp_rx.pop_front(), d);
         end
         chk("rx_full", 0, rx_full_flag);
         t = $urandom;
         i_card.send(t[7:0], 1'b1);
         chk("pe_flag", 1, parity_error_flag);
         if (p)
         begin
            rd(8'h0D, d); chk("rx_byte", t[7:0], d);
         end
         clk(150);
         rd(8'h0C, d); chk("status", 8'h64, d);
         sr();
      end
      $display("test receive done");
      // synchronous card: bit zero straight to and from the line
      sync_card_select <= 1'b1;
      tx_mode <= 1'b1;
      for (int b = 0; b < 2; b++)
      begin
         d = ($urandom & 8'hFE) | b;
         wr(8'h0D, d);
         clk(1);
         chk("sync_line", b, io_line);
         rd(8'h0D, d); chk("sync_rx", b, d[0]);
      end
      hold_low <= 1'b1;
      rd(8'h0D, d); chk("sync_rx", 0, d[0]);
      hold_low <= 1'b0;
      sync_card_select <= 1'b0;
      tx_mode <= 1'b0;
      $display("test sync done");
      // switch to half, back to crystal, to half then soft reset
      for (int s = 0; s < 3; s++)
      begin
         addr <= 8'h0C;
         clock_switch_to_half <= s != 1;
         clock_switch_to_xtal <= s == 1;
         clk(1);
         clock_switch_to_half <= 1'b0;
         clock_switch_to_xtal <= 1'b0;
         if (s == 2)
            sr();
         rd(8'h0C, d); chk("clk_switch", s == 0, d[7]);
      end
      $display("test clock switch done");
      wrap_up();
   end
endmodule
